// ### include/pie_pkg.sv
package pie_pkg;

    // register word addresses (byte address = index * 4)
    localparam logic [3:0] PIE_IDX_EN_ONE    = 4'h0;
    localparam logic [3:0] PIE_IDX_EN_TWO    = 4'h1;
    localparam logic [3:0] PIE_IDX_CTRL      = 4'h2;
    localparam logic [3:0] PIE_IDX_FLAG_ONE  = 4'h3;
    localparam logic [3:0] PIE_IDX_FLAG_TWO  = 4'h4;
    localparam logic [3:0] PIE_IDX_IRQ_STAT  = 4'h5;
    localparam logic [3:0] PIE_IDX_IRQ_MASK  = 4'h6;
    localparam logic [3:0] PIE_IDX_PEND      = 4'h7;

    localparam int         PIE_ADDR_W        = 4;
    localparam logic [7:0] PIE_EN_ONE_RST    = 8'h00;
    localparam logic [7:0] PIE_EN_TWO_RST    = 8'h00;
    // bits 5 and 4 of the second enable register are not built
    localparam logic [7:0] PIE_EN_TWO_IMPL   = 8'hcf;
    // bit 7 of the first register exists only on the large package
    localparam logic [7:0] PIE_EN_ONE_SMALL  = 8'h7f;
    localparam logic [7:0] PIE_EN_ONE_LARGE  = 8'hff;

    // control register fields
    localparam int         PIE_CTRL_GPIE     = 0;
    localparam int         PIE_CTRL_PRIO     = 1;
    localparam logic [1:0] PIE_CTRL_RST      = 2'h0;

    // sticky status bits
    localparam int         PIE_ST_ONE        = 0;
    localparam int         PIE_ST_TWO        = 1;
    localparam logic [1:0] PIE_IRQ_RST       = 2'h0;

    typedef struct packed {
        logic parallel_port_irq_en;
        logic analog_conv_irq_en;
        logic serial_rx_irq_en;
        logic serial_tx_irq_en;
        logic sync_serial_irq_en;
        logic capcomp_one_irq_en;
        logic timer_two_match_irq_en;
        logic timer_one_overflow_irq_en;
    } pie_en_one_t;

    typedef struct packed {
        logic       osc_fail_irq_en;
        logic       comparator_irq_en;
        logic [1:0] unused;
        logic       bus_collision_irq_en;
        logic       voltage_detect_irq_en;
        logic       timer_three_overflow_irq_en;
        logic       capcomp_two_irq_en;
    } pie_en_two_t;

endpackage : pie_pkg

// ### core/pie_gate.sv
module pie_gate
    import pie_pkg::*;
#(
    parameter int WIDTH = 8
)(
    input  wire logic [WIDTH-1:0] flag,
    input  wire logic [WIDTH-1:0] enable,
    output logic      [WIDTH-1:0] pass
);

    // the enable only masks; the flag itself is never touched here
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            assign pass[i] = flag[i] & enable[i];
        end
    endgenerate

endmodule : pie_gate

// ### core/pie_enable_bank.sv
module pie_enable_bank
    import pie_pkg::*;
#(
    parameter bit LARGE_PACKAGE = 1'b1
)(
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    // avalon-mm slave
    input  wire logic [PIE_ADDR_W-1:0] avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output logic      [31:0]           avs_readdata,
    output logic                       avs_waitrequest,
    output logic      [1:0]            avs_response,
    // request flags from peripherals, same clock
    input  wire logic [7:0]            flag_one,
    input  wire logic [7:0]            flag_two,
    // gated requests toward the processor interrupt logic
    output logic      [7:0]            req_one,
    output logic      [7:0]            req_two,
    output logic                       periph_irq,
    output logic                       irq
);

    ////////////////////////////////////////////////////////////////////////////
    // bus handshake: one wait cycle, answer on the second edge

    localparam logic [1:0] RSP_OK     = 2'h0;
    localparam logic [1:0] RSP_DECERR = 2'h3;

    logic              ack_q;
    logic              wr_take;
    logic              lane0;
    logic              mapped;
    logic [7:0]        wdat;
    logic [7:0]        one_mask;

    // the wait cycle lets read data come from a flop instead of the address mux
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign wr_take         = avs_write & ack_q;
    assign lane0           = avs_byteenable[0];
    assign wdat            = avs_writedata[7:0];
    assign mapped          = (avs_address <= PIE_IDX_PEND);
    assign one_mask        = LARGE_PACKAGE ? PIE_EN_ONE_LARGE : PIE_EN_ONE_SMALL;

    // ack_q falls on the taking edge, so back-to-back requests each pay one wait
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= (avs_read | avs_write) & ~ack_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // write strobes: only registers that software may change get one, so writes
    // to the flag copies, the pending bit or unmapped words change nothing

    logic              wr_lane;
    logic              wr_en_one;
    logic              wr_en_two;
    logic              wr_ctrl;
    logic              wr_stat;
    logic              wr_mask;

    assign wr_lane   = wr_take & lane0;
    assign wr_en_one = wr_lane & (avs_address == PIE_IDX_EN_ONE);
    assign wr_en_two = wr_lane & (avs_address == PIE_IDX_EN_TWO);
    assign wr_ctrl   = wr_lane & (avs_address == PIE_IDX_CTRL);
    assign wr_stat   = wr_lane & (avs_address == PIE_IDX_IRQ_STAT);
    assign wr_mask   = wr_lane & (avs_address == PIE_IDX_IRQ_MASK);

    ////////////////////////////////////////////////////////////////////////////
    // enable registers

    pie_en_one_t       en_one_q;
    pie_en_two_t       en_two_q;
    logic [1:0]        ctrl_q;

    // absent positions are masked on the way in, so they can never hold a one
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            en_one_q <= PIE_EN_ONE_RST;
        end
        else if (wr_en_one)
        begin
            en_one_q <= wdat & one_mask;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            en_two_q <= PIE_EN_TWO_RST;
        end
        else if (wr_en_two)
        begin
            en_two_q <= wdat & PIE_EN_TWO_IMPL;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl_q <= PIE_CTRL_RST;
        end
        else if (wr_ctrl)
        begin
            ctrl_q <= wdat[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // masking of peripheral requests

    pie_en_one_t       pass_one;
    pie_en_two_t       pass_two;
    logic              global_ok;

    // flags are held by the peripherals until software clears them there
    pie_gate #(.WIDTH(8)) u_gate_one (
        .flag   (flag_one),
        .enable (en_one_q & one_mask),
        .pass   (pass_one)
    );

    pie_gate #(.WIDTH(8)) u_gate_two (
        .flag   (flag_two),
        .enable (en_two_q & PIE_EN_TWO_IMPL),
        .pass   (pass_two)
    );

    // with priority levels on, the global bit no longer gates peripherals
    assign global_ok  = ctrl_q[PIE_CTRL_PRIO] | ctrl_q[PIE_CTRL_GPIE];
    assign periph_irq = global_ok & (|{pass_one, pass_two});

    ////////////////////////////////////////////////////////////////////////////
    // per-source requests, named so each output bit traces back to its enable

    logic              parallel_port_req;
    logic              analog_conv_req;
    logic              serial_rx_req;
    logic              serial_tx_req;
    logic              sync_serial_req;
    logic              capcomp_one_req;
    logic              timer_two_match_req;
    logic              timer_one_overflow_req;
    logic              osc_fail_req;
    logic              comparator_req;
    logic              bus_collision_req;
    logic              voltage_detect_req;
    logic              timer_three_overflow_req;
    logic              capcomp_two_req;

    assign parallel_port_req        = pass_one.parallel_port_irq_en;
    assign analog_conv_req          = pass_one.analog_conv_irq_en;
    assign serial_rx_req            = pass_one.serial_rx_irq_en;
    assign serial_tx_req            = pass_one.serial_tx_irq_en;
    assign sync_serial_req          = pass_one.sync_serial_irq_en;
    assign capcomp_one_req          = pass_one.capcomp_one_irq_en;
    assign timer_two_match_req      = pass_one.timer_two_match_irq_en;
    assign timer_one_overflow_req   = pass_one.timer_one_overflow_irq_en;
    assign osc_fail_req             = pass_two.osc_fail_irq_en;
    assign comparator_req           = pass_two.comparator_irq_en;
    assign bus_collision_req        = pass_two.bus_collision_irq_en;
    assign voltage_detect_req       = pass_two.voltage_detect_irq_en;
    assign timer_three_overflow_req = pass_two.timer_three_overflow_irq_en;
    assign capcomp_two_req          = pass_two.capcomp_two_irq_en;

    assign req_one = {parallel_port_req, analog_conv_req, serial_rx_req, serial_tx_req,
                      sync_serial_req, capcomp_one_req, timer_two_match_req,
                      timer_one_overflow_req};
    // the two absent positions of the second group are tied low
    assign req_two = {osc_fail_req, comparator_req, 2'h0, bus_collision_req,
                      voltage_detect_req, timer_three_overflow_req, capcomp_two_req};

    ////////////////////////////////////////////////////////////////////////////
    // sticky status on rising edges of each group's gated request

    logic [1:0]        any_q;
    logic [1:0]        any_now;
    logic [1:0]        rise;
    logic [1:0]        stat_d;
    logic [1:0]        stat_q;
    logic [1:0]        mask_q;
    logic [1:0]        w1c;

    // group level only: a second source joining an active group raises no new event
    assign any_now = {|pass_two, |pass_one};
    assign rise    = any_now & ~any_q;
    assign w1c     = wr_stat ? wdat[1:0] : 2'h0;
    // set terms are or-ed in last, so an event in the clearing cycle survives the clear
    assign stat_d  = (stat_q & ~w1c) | rise;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            any_q <= PIE_IRQ_RST;
        end
        else
        begin
            any_q <= any_now;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stat_q <= PIE_IRQ_RST;
        end
        else
        begin
            stat_q <= stat_d;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mask_q <= PIE_IRQ_RST;
        end
        else if (wr_mask)
        begin
            mask_q <= wdat[1:0];
        end
    end

    assign irq = |(stat_q & mask_q);

    ////////////////////////////////////////////////////////////////////////////
    // read path, registered data

    logic [7:0]        rd_mux;

    always_comb
    begin
        rd_mux = 8'h00;
        case (avs_address)
            PIE_IDX_EN_ONE:   rd_mux = en_one_q & one_mask;
            PIE_IDX_EN_TWO:   rd_mux = en_two_q & PIE_EN_TWO_IMPL;
            PIE_IDX_CTRL:     rd_mux = {6'h00, ctrl_q};
            PIE_IDX_FLAG_ONE: rd_mux = flag_one;
            PIE_IDX_FLAG_TWO: rd_mux = flag_two & PIE_EN_TWO_IMPL;
            PIE_IDX_IRQ_STAT: rd_mux = {6'h00, stat_q};
            PIE_IDX_IRQ_MASK: rd_mux = {6'h00, mask_q};
            PIE_IDX_PEND:     rd_mux = {7'h00, periph_irq};
            default:          rd_mux = 8'h00;
        endcase
    end

    // loaded on the first edge of a read and held until the next read starts; writes leave it unchanged
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            avs_readdata <= 32'h0000_0000;
        end
        else if (avs_read & ~ack_q)
        begin
            avs_readdata <= {24'h00_0000, rd_mux};
        end
    end

    // unmapped addresses answer with a decode error, reads as zero
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            avs_response <= RSP_OK;
        end
        else if ((avs_read | avs_write) & ~ack_q)
        begin
            avs_response <= mapped ? RSP_OK : RSP_DECERR;
        end
    end

endmodule : pie_enable_bank

// ### tb/pie_flag_src.sv
module pie_flag_src
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [7:0] set_one,
    input  wire logic [7:0] set_two,
    input  wire logic [7:0] clr_one,
    input  wire logic [7:0] clr_two,
    output logic      [7:0] flag_one,
    output logic      [7:0] flag_two
);
    timeunit 1ns;
    timeprecision 1ns;
    // a flag holds until software clears it; set wins over clear
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
            flag_one <= 8'h00;
        else
            flag_one <= (flag_one & ~clr_one) | set_one;
    // positions 5 and 4 of the second group do not exist
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
            flag_two <= 8'h00;
        else
            flag_two <= ((flag_two & ~clr_two) | set_two) & 8'hcf;
endmodule : pie_flag_src

// ### tb/pie_enable_bank_sva.sv
module pie_enable_bank_sva
    import pie_pkg::*;
(
    input wire logic                  clk,
    input wire logic                  rst_b,
    input wire logic [PIE_ADDR_W-1:0] avs_address,
    input wire logic                  avs_read,
    input wire logic                  avs_write,
    input wire logic [31:0]           avs_readdata,
    input wire logic                  avs_waitrequest,
    input wire logic [1:0]            avs_response,
    input wire logic [7:0]            flag_one,
    input wire logic [7:0]            req_one,
    input wire logic [7:0]            req_two,
    input wire logic                  periph_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_ack;
        ##1 !avs_waitrequest;
    endsequence
    sequence s_done;
        avs_read && !avs_waitrequest;
    endsequence
    a_req_one_sub: assert property ((req_one & ~flag_one) == 8'h00)
        else $error("request one passed without its flag");
    a_req_two_gap: assert property (req_two[5:4] == 2'h0)
        else $error("absent request two bit passed");
    a_periph_needs: assert property (periph_irq |-> (|{req_one, req_two}))
        else $error("peripheral irq without a request");
    a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |-> s_ack)
        else $error("waitrequest held beyond one state");
    a_idle_nowait: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
        else $error("waitrequest while idle");
    a_upper_zero: assert property (s_done |-> avs_readdata[31:8] == 24'h0)
        else $error("readdata upper bits set");
    a_unmapped_err: assert property (s_done and avs_address > 4'h7 |-> avs_response == 2'h3)
        else $error("unmapped read without error");
    a_mapped_ok: assert property (s_done and avs_address < 4'h8 |-> avs_response == 2'h0)
        else $error("mapped read with error");
    a_req_steady: assert property ($stable(flag_one) && !$past(avs_write && !avs_waitrequest)
        |-> $stable(req_one))
        else $error("request one moved without cause");
endmodule : pie_enable_bank_sva
bind pie_enable_bank pie_enable_bank_sva pie_enable_bank_sva_i (.clk, .rst_b, .avs_address,
    .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .avs_response, .flag_one,
    .req_one, .req_two, .periph_irq);

// ### tb/peripheral_irq_enable_bank_tb.sv
module peripheral_irq_enable_bank_tb;
    import pie_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [3:0] a; logic [7:0] w; logic [7:0] e;} pie_row_t;
    logic        clk = 1'b0, rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'h1;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, junk;
    logic        avs_waitrequest, periph_irq, irq;
    logic [1:0]  avs_response;
    logic [7:0]  flag_one, flag_two, req_one, req_two;
    logic [7:0]  s1 = 8'h0, s2 = 8'h0, c1 = 8'h0, c2 = 8'h0;
    int          num_errors = 0, num_checks = 0;
    pie_row_t    rows [8] = '{'{4'h0, 8'h80, 8'h80}, '{4'h0, 8'h08, 8'h08},
        '{4'h0, 8'h04, 8'h04}, '{4'h0, 8'h02, 8'h02}, '{4'h0, 8'h70, 8'h70},
        '{4'h1, 8'hff, 8'hcf}, '{4'h1, 8'h30, 8'h00}, '{4'h0, 8'h01, 8'h01}};
    always #25 clk = ~clk;
    pie_enable_bank pie_enable_bank_i (.clk, .rst_b, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response,
        .flag_one, .flag_two, .req_one, .req_two, .periph_irq, .irq);
    pie_flag_src pie_flag_src_i (.clk, .rst_b, .set_one(s1), .set_two(s2), .clr_one(c1),
        .clr_two(c2), .flag_one, .flag_two);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // values read right after an edge are the ones sampled at that edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
        output logic [31:0] r);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        // no limit of its own: the watchdog ends a wait that never finishes
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        r = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic rdc(input logic [3:0] a, input logic [7:0] e, input string nm);
        logic [31:0] r;
        bus(1'b0, a, 8'h00, r);
        chk(r, {24'h0, e}, nm);
    endtask : rdc
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #100000;
        num_errors++;
        complete_run();
    end
    initial
    begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rdc(4'h0, 8'h00, "enable one reset");
        rdc(4'h1, 8'h00, "enable two reset");
        rdc(4'h8, 8'h00, "unmapped");
        $display("reset test done");
        s1 <= 8'hff;
        s2 <= 8'hff;
        @(posedge clk);
        s1 <= 8'h00;
        s2 <= 8'h00;
        foreach (rows[i])
        begin
            bus(1'b1, rows[i].a, rows[i].w, junk);
            rdc(rows[i].a, rows[i].e, "readback");
            chk(rows[i].a ? req_two : req_one, rows[i].e, "request");
        end
        $display("table test done");
        chk(periph_irq, 1'b0, "global off");
        bus(1'b1, 4'h2, 8'h01, junk);
        chk(periph_irq, 1'b1, "global on");
        bus(1'b1, 4'h2, 8'h02, junk);
        chk(periph_irq, 1'b1, "priority mode");
        bus(1'b1, 4'h2, 8'h00, junk);
        rdc(4'h3, 8'hff, "flag kept");
        $display("gate test done");
        // clear flags and stale status before the interrupt checks
        c1 <= 8'hff;
        c2 <= 8'hff;
        @(posedge clk);
        c1 <= 8'h00;
        c2 <= 8'h00;
        bus(1'b1, 4'h5, 8'h03, junk);
        bus(1'b1, 4'h6, 8'h01, junk);
        s1 <= 8'h01;
        @(posedge clk);
        s1 <= 8'h00;
        repeat (2) @(posedge clk);
        chk(irq, 1'b1, "irq raised");
        rdc(4'h5, 8'h01, "status set");
        bus(1'b1, 4'h5, 8'h01, junk);
        chk(irq, 1'b0, "irq cleared");
        bus(1'b1, 4'h6, 8'h00, junk);
        c1 <= 8'h01;
        @(posedge clk);
        c1 <= 8'h00;
        s1 <= 8'h01;
        @(posedge clk);
        s1 <= 8'h00;
        repeat (2) @(posedge clk);
        chk(irq, 1'b0, "irq masked");
        rdc(4'h5, 8'h01, "status masked");
        $display("interrupt test done");
        // reset again in mid-run: both enable registers, the status and request one must read clear
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rdc(4'h0, 8'h00, "enable one mid reset");
        rdc(4'h1, 8'h00, "enable two mid reset");
        rdc(4'h5, 8'h00, "status mid reset");
        chk(req_one, 8'h00, "request one mid reset");
        // a write with byte lane 0 off must be ignored
        avs_byteenable <= 4'h0;
        bus(1'b1, 4'h0, 8'hff, junk);
        avs_byteenable <= 4'h1;
        rdc(4'h0, 8'h00, "lane off write");
        $display("reset and lane test done");
        complete_run();
    end
endmodule : peripheral_irq_enable_bank_tb
